// File: ascm_regs.svh
`ifndef ASCM_REGS_SVH
`define ASCM_REGS_SVH

// ----------------------------------------
// clock and timing figures
// ----------------------------------------
`define ASCM_MCLK_HZ          25000000
`define ASCM_MCLK_MHZ         25
`define ASCM_POR_LONG_MS      100
`define ASCM_POR_SHORT_MS     12
`define ASCM_RESTART_US       100
`define ASCM_RESTART_CYC      (`ASCM_RESTART_US * `ASCM_MCLK_MHZ)
`define ASCM_UCLK_DELAY_NS    600
`define ASCM_UCLK_DELAY_CYC   ((`ASCM_UCLK_DELAY_NS * `ASCM_MCLK_MHZ + 999) / 1000)
`define ASCM_INIT_CYCLES      4436
`define ASCM_INT_OSC_MHZ      10
`define ASCM_INT_OSC_DIV      ((`ASCM_MCLK_MHZ + `ASCM_INT_OSC_MHZ - 1) / `ASCM_INT_OSC_MHZ)
`define ASCM_SCLK_HALF        2
`define ASCM_CFG_BITS_DEF     4096

// ----------------------------------------
// command, strap and option fields
// ----------------------------------------
`define ASCM_READ_OPCODE      8'h03
`define ASCM_START_ADDR       24'h00_0000
`define ASCM_CMD_BITS         6'h20
`define ASCM_SCHEME_FAST      3'h3
`define ASCM_INIT_DONE_BIT    0

`endif

// File: ascm_pkg.sv
package ascm_pkg;

    typedef enum logic [8:0] {
        st_por       = 9'h001,
        st_reset     = 9'h002,
        st_cmd       = 9'h004,
        st_read      = 9'h008,
        st_wait_done = 9'h010,
        st_init_wait = 9'h020,
        st_init      = 9'h040,
        st_user      = 9'h080,
        st_error     = 9'h100
    } ascm_state_type;

endpackage

// File: ascm_sync.sv
`timescale 1ns/1ps

// two-flop synchroniser
module ascm_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

// File: ascm_config_master.sv
`timescale 1ns/1ps
`include "ascm_regs.svh"

// Functional notes
// - power-on hold lasts 100 ms, or 12 ms when delay select high
// - during power-on hold status and done low, user io tri-stated
// - weak pull-ups on user io when pull-up control low, from the end of power-on hold until user mode
// - stages run reset, configure, initialise; reset while request or status low
// - status released after power-on hold, then configuration starts
// - serial clock generated internally and paces the whole configuration
// - outputs change on serial clock fall; read data latched on next fall
// - flash select low, read command and address shifted out, data shifted in
// - done released after last bit; initialise only once done line high
// - flash pins keep weak pull-ups, become inputs after configuration
// - initialise on internal oscillator, or on user clock when enabled
// - user clock used 600 ns after done high, 4436 cycles to user mode
// - init-done pin low once option bit loaded, released in user mode
// - user mode drops weak pull-ups and enables user io
// - on error status driven low and done kept low
// - auto-restart: flash select pulsed, status released within 100 us, retry
// - request low forces reset with status, done low; restart on release
// - chain enable input low needed; chain enable out low after own data
// - shared done held low until own data complete; all initialise together
// - any chained fail pulls status low; chain restarts after timeout
// - one bitstream bit per serial clock cycle
module ascm_config_master #(
    parameter int unsigned POR_LONG_CYCLES  = `ASCM_POR_LONG_MS * (`ASCM_MCLK_HZ / 1000),
    parameter int unsigned POR_SHORT_CYCLES = `ASCM_POR_SHORT_MS * (`ASCM_MCLK_HZ / 1000),
    parameter int unsigned CFG_BITS         = `ASCM_CFG_BITS_DEF
) (
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic       por_delay_select,
    input  wire logic       io_weak_pullup_n,
    input  wire logic [2:0] scheme_select,
    input  wire logic       config_request_n,
    input  wire logic       auto_restart_enable,
    input  wire logic       user_clock_enable,
    input  wire logic       user_init_clock,
    input  wire logic       frame_error,
    input  wire logic       status_in,
    output logic            status_out,
    output logic            status_oe,
    input  wire logic       done_in,
    output logic            done_out,
    output logic            done_oe,
    output logic            init_done_out,
    output logic            init_done_oe,
    output logic            serial_config_clock,
    output logic            flash_select_out_n,
    output logic            command_serial_out,
    output logic            flash_pins_oe,
    output logic            flash_pins_pullup,
    input  wire logic       serial_data_in,
    input  wire logic       chain_enable_in_n,
    output logic            chain_enable_out_n,
    output logic [7:0]      cfg_byte,
    output logic            cfg_byte_valid,
    output logic            user_io_oe,
    output logic            user_io_pullup_en,
    output logic            user_mode
);

    // ----------------------------------------
    // derived counts
    // ----------------------------------------
    localparam logic [31:0] RESTART_CYC = 32'(`ASCM_RESTART_CYC);
    localparam logic [31:0] UCLK_DELAY  = 32'(`ASCM_UCLK_DELAY_CYC);
    localparam logic [31:0] INIT_CYC    = 32'(`ASCM_INIT_CYCLES);
    localparam logic [1:0]  OSC_DIV     = 2'(`ASCM_INT_OSC_DIV);
    localparam logic [1:0]  SCLK_HALF   = 2'(`ASCM_SCLK_HALF);
    localparam logic [31:0] LAST_BIT    = 32'(CFG_BITS - 1);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [10:0] raw;
    logic [10:0] syn;
    logic        s_por_delay_select;
    logic        s_pullup_n;
    logic [2:0]  s_scheme_select;
    logic        s_req_n;
    logic        s_status;
    logic        s_done;
    logic        s_din;
    logic        s_ce_n;
    logic        s_uclk;

    assign raw = {por_delay_select, io_weak_pullup_n, scheme_select, config_request_n,
                  status_in, done_in, serial_data_in, chain_enable_in_n, user_init_clock};

    ascm_sync #(
        .W (11)
    ) u_sync (
        .mclk (mclk),
        .rstn (rstn),
        .d    (raw),
        .q    (syn)
    );

    assign s_por_delay_select   = syn[10];
    assign s_pullup_n = syn[9];
    assign s_scheme_select     = syn[8:6];
    assign s_req_n    = syn[5];
    assign s_status   = syn[4];
    assign s_done     = syn[3];
    assign s_din      = syn[2];
    assign s_ce_n     = syn[1];
    assign s_uclk     = syn[0];

    // ----------------------------------------
    // state and shared counters
    // ----------------------------------------
    ascm_pkg::ascm_state_type state;
    ascm_pkg::ascm_state_type next_state;
    logic [31:0]              cnt;
    logic [31:0]              bit_cnt;
    logic [5:0]               cmd_cnt;
    logic [31:0]              cmd_sr;
    logic [7:0]               byte_sr;
    logic [1:0]               ph;
    logic [1:0]               osc;
    logic                     uclk_prev;
    logic                     por_long;
    logic                     init_done_en;
    logic                     sclk_active;
    logic                     fall;
    logic                     tick;
    logic                     scheme_select_ok;

    assign sclk_active = (state == ascm_pkg::st_cmd) || (state == ascm_pkg::st_read);
    assign fall        = sclk_active && serial_config_clock && (ph == SCLK_HALF - 2'h1);
    assign tick        = user_clock_enable ? (s_uclk && !uclk_prev)
                                           : (osc == OSC_DIV - 2'h1);
    assign scheme_select_ok     = (s_scheme_select == `ASCM_SCHEME_FAST);

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            por_long <= 1'b1;
        end else if (state == ascm_pkg::st_por && cnt == 32'h0000_0003) begin
            por_long <= !s_por_delay_select;
        end
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            ascm_pkg::st_por: begin
                if (cnt > 32'h0000_0003 &&
                    cnt >= (por_long ? POR_LONG_CYCLES : POR_SHORT_CYCLES) - 1) begin
                    next_state = ascm_pkg::st_reset;
                end
            end
            ascm_pkg::st_reset: begin
                if (s_req_n && s_status && !s_ce_n && scheme_select_ok) begin
                    next_state = ascm_pkg::st_cmd;
                end
            end
            ascm_pkg::st_cmd: begin
                if (fall && cmd_cnt == `ASCM_CMD_BITS) begin
                    next_state = ascm_pkg::st_read;
                end
            end
            ascm_pkg::st_read: begin
                if (frame_error || !s_status) begin
                    next_state = ascm_pkg::st_error;
                end else if (fall && bit_cnt == LAST_BIT) begin
                    next_state = ascm_pkg::st_wait_done;
                end
            end
            ascm_pkg::st_wait_done: begin
                if (!s_status) begin
                    next_state = ascm_pkg::st_error;
                end else if (s_done) begin
                    next_state = user_clock_enable ? ascm_pkg::st_init_wait
                                                   : ascm_pkg::st_init;
                end
            end
            ascm_pkg::st_init_wait: begin
                if (cnt >= UCLK_DELAY - 32'h0000_0001) begin
                    next_state = ascm_pkg::st_init;
                end
            end
            ascm_pkg::st_init: begin
                if (tick && cnt >= INIT_CYC - 32'h0000_0001) begin
                    next_state = ascm_pkg::st_user;
                end
            end
            ascm_pkg::st_user: begin
                next_state = ascm_pkg::st_user;
            end
            ascm_pkg::st_error: begin
                // status stays low until the timeout expires when auto-restart is enabled, otherwise until request goes low and is released again
                if (auto_restart_enable && cnt >= RESTART_CYC - 32'h0000_0001) begin
                    next_state = ascm_pkg::st_reset;
                end
            end
            default: begin
                next_state = ascm_pkg::st_por;
            end
        endcase
        // request low wins over every stage but power-on
        if (!s_req_n && state != ascm_pkg::st_por) begin
            next_state = ascm_pkg::st_reset;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state <= ascm_pkg::st_por;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn || next_state != state) begin
            cnt <= 32'h0000_0000;
        end else if (state != ascm_pkg::st_init || tick) begin
            cnt <= cnt + 32'h0000_0001;
        end
    end

    // ----------------------------------------
    // init clock sources
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            osc       <= 2'h0;
            uclk_prev <= 1'b0;
        end else begin
            osc       <= (osc == OSC_DIV - 2'h1) ? 2'h0 : osc + 2'h1;
            uclk_prev <= s_uclk;
        end
    end

    // ----------------------------------------
    // serial clock divider
    // ----------------------------------------
    // mclk/4; two-cycle halves give the synced data time
    always_ff @(posedge mclk) begin
        if (!rstn || !sclk_active) begin
            ph                  <= 2'h0;
            serial_config_clock <= 1'b0;
        end else if (ph == SCLK_HALF - 2'h1) begin
            ph                  <= 2'h0;
            serial_config_clock <= !serial_config_clock;
        end else begin
            ph <= ph + 2'h1;
        end
    end

    // ----------------------------------------
    // command shifter
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cmd_sr             <= 32'h0000_0000;
            cmd_cnt            <= 6'h00;
            command_serial_out <= 1'b1;
        end else if (state == ascm_pkg::st_reset) begin
            cmd_sr             <= {`ASCM_READ_OPCODE, `ASCM_START_ADDR};
            cmd_cnt            <= 6'h00;
            command_serial_out <= 1'b1;
        end else if (state == ascm_pkg::st_cmd && fall) begin
            // msb first, driven on the falling edge
            command_serial_out <= cmd_sr[31];
            cmd_sr             <= {cmd_sr[30:0], 1'b0};
            cmd_cnt            <= cmd_cnt + 6'h01;
        end
    end

    // ----------------------------------------
    // data receiver
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!rstn || state == ascm_pkg::st_reset) begin
            bit_cnt        <= 32'h0000_0000;
            byte_sr        <= 8'h00;
            cfg_byte       <= 8'h00;
            cfg_byte_valid <= 1'b0;
        end else begin
            cfg_byte_valid <= 1'b0;
            if (state == ascm_pkg::st_read && fall) begin
                // one bit latched per fall, lsb of each byte first
                byte_sr <= {s_din, byte_sr[7:1]};
                bit_cnt <= bit_cnt + 32'h0000_0001;
                if (bit_cnt[2:0] == 3'h7) begin
                    cfg_byte       <= {s_din, byte_sr[7:1]};
                    cfg_byte_valid <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn || state == ascm_pkg::st_reset) begin
            init_done_en <= 1'b0;
        end else if (state == ascm_pkg::st_read && fall &&
                     bit_cnt == 32'(`ASCM_INIT_DONE_BIT)) begin
            init_done_en <= s_din;
        end
    end

    // ----------------------------------------
    // pin drivers
    // ----------------------------------------
    assign status_out        = 1'b0;
    assign done_out          = 1'b0;
    assign init_done_out     = 1'b0;
    assign flash_pins_pullup = 1'b1;
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            status_oe <= 1'b1;
            done_oe   <= 1'b1;
        end else begin
            // open drain: oe high pulls the line low
            status_oe <= (next_state == ascm_pkg::st_por) ||
                         (next_state == ascm_pkg::st_error) ||
                         (next_state == ascm_pkg::st_reset && !s_req_n);
            // done stays low until own data complete
            done_oe   <= !(next_state == ascm_pkg::st_wait_done ||
                           next_state == ascm_pkg::st_init_wait ||
                           next_state == ascm_pkg::st_init ||
                           next_state == ascm_pkg::st_user);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            flash_select_out_n <= 1'b1;
            flash_pins_oe      <= 1'b0;
            chain_enable_out_n <= 1'b1;
        end else begin
            // high again after last bit and on error, pulsing the flash
            flash_select_out_n <= !(next_state == ascm_pkg::st_cmd ||
                                    next_state == ascm_pkg::st_read);
            flash_pins_oe      <= (next_state == ascm_pkg::st_cmd ||
                                   next_state == ascm_pkg::st_read);
            chain_enable_out_n <= !(next_state == ascm_pkg::st_wait_done ||
                                    next_state == ascm_pkg::st_init_wait ||
                                    next_state == ascm_pkg::st_init ||
                                    next_state == ascm_pkg::st_user);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            init_done_oe      <= 1'b0;
            user_io_oe        <= 1'b0;
            user_io_pullup_en <= 1'b0;
            user_mode         <= 1'b0;
        end else begin
            init_done_oe      <= init_done_en && next_state != ascm_pkg::st_user &&
                                 next_state != ascm_pkg::st_reset;
            user_io_oe        <= (next_state == ascm_pkg::st_user);
            user_io_pullup_en <= !s_pullup_n && next_state != ascm_pkg::st_por &&
                                 next_state != ascm_pkg::st_user;
            user_mode         <= (next_state == ascm_pkg::st_user);
        end
    end
endmodule

// File: ascm_checker.sv
`timescale 1ns/1ps
module ascm_checker #(
    parameter int unsigned POR_LONG_CYCLES  = 20,
    parameter int unsigned POR_SHORT_CYCLES = 10,
    parameter int unsigned CFG_BITS         = 64
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic por_delay_select,
    input wire logic config_request_n,
    input wire logic status_oe,
    input wire logic done_oe,
    input wire logic init_done_oe,
    input wire logic serial_config_clock,
    input wire logic flash_select_out_n,
    input wire logic command_serial_out,
    input wire logic flash_pins_oe,
    input wire logic flash_pins_pullup,
    input wire logic chain_enable_out_n,
    input wire logic cfg_byte_valid,
    input wire logic user_io_oe,
    input wire logic user_io_pullup_en,
    input wire logic user_mode
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // ----------------------------------------
    // helper counters
    // ----------------------------------------
    logic [31:0] por_cnt;
    logic [15:0] byte_cnt;
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            por_cnt <= 32'h0000_0000;
        end else if (por_cnt < POR_LONG_CYCLES) begin
            por_cnt <= por_cnt + 32'h0000_0001;
        end
    end
    always_ff @(posedge mclk) begin
        if (!rstn || status_oe || user_mode) begin
            byte_cnt <= 16'h0000;
        end else if (cfg_byte_valid) begin
            byte_cnt <= byte_cnt + 16'h0001;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    sequence first_rise;
        !serial_config_clock [*2] ##1 serial_config_clock;
    endsequence
    sequence high_half;
        (serial_config_clock || status_oe) ##1 !serial_config_clock;
    endsequence
    por_hold_a: assert property (
        por_cnt < (por_delay_select ? POR_SHORT_CYCLES : POR_LONG_CYCLES)
        |-> status_oe && done_oe && !user_io_oe) else $error("hold released early");
    flash_start_a: assert property (
        $fell(flash_select_out_n) |-> first_rise) else $error("bad serial clock start");
    clk_half_a: assert property (
        $rose(serial_config_clock) |=> high_half) else $error("bad serial clock half");
    cmd_edge_a: assert property (
        $changed(command_serial_out) |-> $fell(serial_config_clock) || flash_select_out_n)
        else $error("command bit off falling edge");
    clk_idle_a: assert property (
        flash_select_out_n && $past(flash_select_out_n) |-> !serial_config_clock)
        else $error("serial clock runs while idle");
    pins_float_a: assert property (
        flash_pins_pullup && (!flash_pins_oe || !flash_select_out_n))
        else $error("flash pins driven while idle");
    done_release_a: assert property (
        $fell(done_oe) |-> flash_select_out_n && !chain_enable_out_n
        && cfg_byte_valid && byte_cnt == CFG_BITS / 8 - 1) else $error("done released early");
    user_entry_a: assert property (
        user_mode |-> user_io_oe && !user_io_pullup_en && !init_done_oe)
        else $error("user mode pins wrong");
    req_reset_a: assert property (
        !config_request_n [*3] |=> ##[0:2] (status_oe && done_oe && !user_mode))
        else $error("request low not obeyed");
    err_done_a: assert property (
        status_oe |-> done_oe) else $error("done released with status low");
    byte_space_a: assert property (
        cfg_byte_valid |=> (!cfg_byte_valid) [*8]) else $error("bytes too close");
endmodule

bind ascm_config_master ascm_checker #(.POR_LONG_CYCLES(POR_LONG_CYCLES),
    .POR_SHORT_CYCLES(POR_SHORT_CYCLES), .CFG_BITS(CFG_BITS)) i_ascm_checker (
    .mclk, .rstn, .por_delay_select, .config_request_n, .status_oe, .done_oe,
    .init_done_oe, .serial_config_clock, .flash_select_out_n, .command_serial_out,
    .flash_pins_oe, .flash_pins_pullup, .chain_enable_out_n, .cfg_byte_valid,
    .user_io_oe, .user_io_pullup_en, .user_mode);

// File: ascm_flash_model.sv
`timescale 1ns/1ps
module ascm_flash_model #(
    parameter int unsigned NBITS = 64
) (
    input  wire logic             sclk,
    input  wire logic             sel_n,
    input  wire logic             cmd_in,
    input  wire logic [NBITS-1:0] image,
    output logic                  data_out,
    output logic [31:0]           cmd_word
);
    // ----------------------------------------
    // serial memory behaviour
    // ----------------------------------------
    int unsigned falls;
    initial begin
        falls = 0;
        data_out = 1'b1;
        cmd_word = 32'h0000_0000;
    end
    always @(posedge sel_n) begin
        falls = 0;
        data_out = 1'b1;
    end
    always @(negedge sel_n) cmd_word = 32'h0000_0000;
    always @(posedge sclk) begin
        if (!sel_n && falls >= 1 && falls <= 32) cmd_word = {cmd_word[30:0], cmd_in};
    end
    // toggles past the image, so no stale bit
    always @(negedge sclk) begin
        if (!sel_n) begin
            falls++;
            if (falls >= 33) data_out = (falls - 33 < NBITS) ? image[falls-33] : ~data_out;
        end
    end
endmodule

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam int unsigned CFG = 64;
    logic           mclk, rstn, por_delay_select, io_weak_pullup_n, config_request_n;
    logic           auto_restart_enable, user_clock_enable, user_init_clock, frame_error;
    logic           status_in, status_oe, done_in, done_oe, init_done_oe, serial_config_clock;
    logic           flash_select_out_n, command_serial_out, flash_pins_oe, flash_pins_pullup;
    logic           serial_data_in, chain_enable_in_n, chain_enable_out_n, cfg_byte_valid;
    logic           user_io_oe, user_io_pullup_en, user_mode, peer_status_pull, peer_done_hold;
    logic [2:0]     scheme_select;
    logic [7:0]     cfg_byte;
    logic [CFG-1:0] image;
    logic [31:0]    cmd_word;
    logic [7:0]     exp_q[$];
    int             err_total, comparisons, n;
    // ----------------------------------------
    // shared open-drain lines and instances
    // ----------------------------------------
    assign status_in = !(status_oe || peer_status_pull);
    assign done_in   = !(done_oe || peer_done_hold);
    ascm_config_master #(.POR_LONG_CYCLES(20), .POR_SHORT_CYCLES(10), .CFG_BITS(CFG))
    i_ascm_config_master (.mclk, .rstn, .por_delay_select, .io_weak_pullup_n, .scheme_select,
        .config_request_n, .auto_restart_enable, .user_clock_enable, .user_init_clock,
        .frame_error, .status_in, .status_out(), .status_oe, .done_in, .done_out(), .done_oe,
        .init_done_out(), .init_done_oe, .serial_config_clock, .flash_select_out_n,
        .command_serial_out, .flash_pins_oe, .flash_pins_pullup, .serial_data_in,
        .chain_enable_in_n, .chain_enable_out_n, .cfg_byte, .cfg_byte_valid, .user_io_oe,
        .user_io_pullup_en, .user_mode);
    ascm_flash_model #(.NBITS(CFG)) i_ascm_flash_model (.sclk(serial_config_clock),
        .sel_n(flash_select_out_n), .cmd_in(command_serial_out), .image,
        .data_out(serial_data_in), .cmd_word);
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        user_init_clock = 1'b0;
        #7;
        forever #160 user_init_clock = ~user_init_clock;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge mclk);
    endtask
    function automatic logic probe(input int k);
        case (k)
            0: return status_oe;
            1: return flash_select_out_n;
            2: return done_oe;
            default: return user_mode;
        endcase
    endfunction
    // bounded; a miss ends the run
    task automatic wait_on(input int k, input logic v, input int lim);
        for (n = 0; probe(k) !== v && n < lim; n++) @(negedge mclk);
        if (probe(k) !== v) begin
            check("wait", v, probe(k));
            conclude();
        end
    endtask
    task automatic reset();
        rstn = 1'b0;
        cyc(4);
        rstn = 1'b1;
    endtask
    task automatic load(input logic opt);
        image = {$urandom, $urandom};
        image[0] = opt;
        exp_q.delete();
        for (int i = 0; i < CFG / 8; i++) exp_q.push_back(image[8*i +: 8]);
    endtask
    task automatic req_pulse();
        config_request_n = 1'b0;
        cyc(50);
        check("req", 4'b1100, {status_oe, done_oe, user_io_oe, user_mode});
        config_request_n = 1'b1;
    endtask
    // peer holds done low, as a later chain member
    task automatic cfg_run(input logic opt, input logic uclk);
        int lo;
        load(opt);
        user_clock_enable = uclk;
        peer_done_hold = 1'b1;
        lo = uclk ? 4436 * 8 - 8 : 4436 * 3;
        wait_on(1, 1'b0, 300);
        check("pullup", !io_weak_pullup_n, user_io_pullup_en);
        check("io_oe", 0, user_io_oe);
        wait_on(1, 1'b1, 2000);
        cyc(1);
        check("cmd", 32'h0300_0000, cmd_word);
        check("left", 0, exp_q.size());
        check("chain", 0, chain_enable_out_n);
        wait_on(2, 1'b0, 10);
        check("init_done", opt, init_done_oe);
        cyc(100);
        check("early", 0, user_mode);
        peer_done_hold = 1'b0;
        wait_on(3, 1'b1, 40000);
        check("init len", 1, n >= lo && n <= lo + 60);
        check("user io", 3'b010, {init_done_oe, user_io_oe, user_io_pullup_en});
        $display("config run done");
    endtask
    always @(negedge mclk) begin
        if (cfg_byte_valid === 1'b1) begin
            if (exp_q.size() == 0) check("spare byte", 0, 1);
            else check("cfg_byte", exp_q.pop_front(), cfg_byte);
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {rstn, io_weak_pullup_n, auto_restart_enable, user_clock_enable, frame_error} = '0;
        {peer_status_pull, peer_done_hold, chain_enable_in_n} = '0;
        config_request_n = 1'b1;
        scheme_select = 3'b011;
        por_delay_select = 1'b1;
        image = '1;
        err_total = 0;
        comparisons = 0;
        void'($urandom(32'h73a1));
        reset();
        check("hold", 1, status_oe && done_oe && !user_io_oe);
        wait_on(0, 1'b0, 200);
        check("short hold", 1, n >= 10 && n <= 20);
        $display("short hold done");
        scheme_select = 3'b010;
        por_delay_select = 1'b0;
        reset();
        wait_on(0, 1'b0, 200);
        check("long hold", 1, n >= 20 && n <= 30);
        cyc(50);
        check("bad scheme", 1, flash_select_out_n);
        scheme_select = 3'b011;
        chain_enable_in_n = 1'b1;
        cyc(50);
        check("chain off", 1, flash_select_out_n);
        chain_enable_in_n = 1'b0;
        cfg_run(1'b1, 1'b0);
        req_pulse();
        auto_restart_enable = 1'b1;
        load(1'b0);
        wait_on(1, 1'b0, 300);
        cyc(200);
        peer_status_pull = 1'b1;
        wait_on(0, 1'b1, 10);
        peer_status_pull = 1'b0;
        check("err", 2'b11, {done_oe, flash_select_out_n});
        wait_on(0, 1'b0, 3000);
        check("restart", 1, n >= 2 && n <= 2500);
        load(1'b0);
        wait_on(1, 1'b0, 100);
        $display("auto restart done");
        auto_restart_enable = 1'b0;
        cyc(200);
        frame_error = 1'b1;
        wait_on(0, 1'b1, 10);
        frame_error = 1'b0;
        cyc(3000);
        check("stuck", 3'b111, {status_oe, done_oe, flash_select_out_n});
        io_weak_pullup_n = 1'b1;
        req_pulse();
        cfg_run(1'b0, 1'b1);
        conclude();
    end
endmodule
